// >>> verilog/spcp_top.sv
// Serial passive configuration port: power-up, load and startup
//
// Contract
// - Power-on reset 100 ms, or 12 ms if select
// - In reset drive status low, user pins off
// - Weak pull-ups on while pull-up pin low; the code keeps them off in power-on reset and user mode
// - Stay in reset while request or status low
// - Request high releases status, configuration starts
// - Done rises after all data received
// - Startup needs no user startup clock
// - Chain enable out feeds next device in
// - Init and user mode only when done high
// - Error pulls shared status low, halts chain
// - Last bits clocked before done rises
//
// Implementation choices: the AHB-Lite register port and the placing of the registers.
`timescale 1ns/100ps
module spcp_top #(
	parameter int unsigned POR_LONG_CYC  =
		spcp_pkg::POR_LONG_MS * spcp_pkg::CYC_PER_MS,
	parameter int unsigned POR_SHORT_CYC =
		spcp_pkg::POR_SHORT_MS * spcp_pkg::CYC_PER_MS
) (
	input  wire logic                   ref_clk_i,
	input  wire logic                   resetn_i,
	input  wire logic                   config_clock_in_i,
	input  wire spcp_pkg::spcp_ahb_req_t ahb_i,
	output spcp_pkg::spcp_ahb_rsp_t      ahb_o,
	input  wire logic                   config_request_i,
	input  wire logic                   status_n_i,
	output logic                        status_n_o,
	output logic                        status_n_oe_o,
	input  wire logic                   done_i,
	output logic                        done_o,
	output logic                        done_oe_o,
	input  wire logic                   serial_data_in_i,
	input  wire logic                   chain_enable_in_n_i,
	output logic                        chain_enable_out_n_o,
	input  wire logic                   por_delay_select_i,
	input  wire logic                   io_weak_pullup_n_i,
	output logic                        weak_pullup_en_o,
	output logic                        user_io_oe_o,
	output logic                        user_mode_o
);
	import spcp_pkg::*;

	// ****************************************************************
	// State and helpers
	// ****************************************************************
	spcp_sys_t            s;
	spcp_sys_t            next_s;
	spcp_link_t           l;
	spcp_link_t           next_l;
	logic [WORD_W-1:0]    mem_rdata;
	logic                 word_ev;
	logic                 to_reset;
	logic [POR_CNT_W-1:0] por_limit;
	logic [CNT_W-1:0]     words_inc;
	wire  logic           link_rst_n;

	assign link_rst_n = s.link_run;

	function automatic logic [WORD_W-1:0] rd_word(
		input logic [ADDR_W-1:0] a,
		input spcp_sys_t         st,
		input logic [WORD_W-1:0] m
	);
		spcp_stat_t t;
		t = '0;
		t.state = st.state;
		t.error = st.error;
		t.done_released = !st.done_oe;
		t.done_line = st.dn2;
		t.user_mode = st.user_mode;
		if (a == LENGTH_OFS) begin
			rd_word = WORD_W'(st.length);
		end else if (a == STATUS_OFS) begin
			rd_word = t;
		end else if (a == COUNT_OFS) begin
			rd_word = WORD_W'(st.words);
		end else if (a[ADDR_W-1:MEM_AW+2] == MEM_SEL) begin
			rd_word = m;
		end else begin
			rd_word = '0;
		end
	endfunction : rd_word

	spcp_word_store u_store (
		.clk_i    (ref_clk_i),
		.resetn_i (resetn_i),
		.we_i     (s.mem_we),
		.waddr_i  (s.mem_waddr),
		.wdata_i  (s.mem_wdata),
		.raddr_i  (ahb_i.haddr[MEM_AW+1:2]),
		.rdata_o  (mem_rdata)
	);

	// ****************************************************************
	// Link side: serial shift on the configuration clock
	// ****************************************************************
	always_comb begin
		next_l = l;
		if (!chain_enable_in_n_i) begin
			next_l.shift = {l.shift[WORD_W-2:0], serial_data_in_i};
			next_l.bitcnt = l.bitcnt + 5'h1;
			if (l.bitcnt == BIT_LAST) begin
				next_l.word = {l.shift[WORD_W-2:0], serial_data_in_i};
				next_l.tog = !l.tog;
			end
		end
	end

	always_ff @(posedge config_clock_in_i or negedge link_rst_n) begin
		if (!link_rst_n) begin
			l <= '0;
		end else begin
			l <= next_l;
		end
	end

	// ****************************************************************
	// Control side: power-up, stages and handshake
	// ****************************************************************
	always_comb begin
		next_s = s;
		next_s.req1 = config_request_i;
		next_s.req2 = s.req1;
		next_s.st1 = status_n_i;
		next_s.st2 = s.st1;
		next_s.dn1 = done_i;
		next_s.dn2 = s.dn1;
		next_s.sel1 = por_delay_select_i;
		next_s.sel2 = s.sel1;
		next_s.pu1 = io_weak_pullup_n_i;
		next_s.pu2 = s.pu1;
		next_s.tg1 = l.tog;
		next_s.tg2 = s.tg1;
		next_s.tg3 = s.tg2;
		next_s.mem_we = 1'b0;
		word_ev = s.tg2 ^ s.tg3;
		words_inc = s.words + 16'h1;
		por_limit = s.sel2 ? POR_CNT_W'(POR_SHORT_CYC)
			: POR_CNT_W'(POR_LONG_CYC);
		to_reset = (s.state == ST_CONFIG || s.state == ST_WAIT
			|| s.state == ST_INIT || s.state == ST_USER)
			&& (!s.req2 || !s.st2);

		case (s.state)
		ST_POR: begin
			next_s.status_oe = 1'b1;
			next_s.por_cnt = s.por_cnt + 20'h1;
			if (s.por_cnt >= por_limit) begin
				next_s.state = ST_RESET;
				next_s.por_cnt = '0;
			end
		end
		ST_RESET: begin
			next_s.status_oe = !s.req2;
			if (s.req2 && s.st2) begin
				next_s.state = ST_CONFIG;
				next_s.link_run = 1'b1;
				next_s.error = 1'b0;
			end
		end
		ST_CONFIG: begin
			if (word_ev) begin
				if (s.words == '0 && l.word != PREAMBLE) begin
					next_s.state = ST_ERROR;
					next_s.error = 1'b1;
					next_s.status_oe = 1'b1;
					next_s.link_run = 1'b0;
				end else begin
					next_s.words = words_inc;
					next_s.mem_we = (s.words < CNT_W'(2**MEM_AW));
					next_s.mem_waddr = s.words[MEM_AW-1:0];
					next_s.mem_wdata = l.word;
					if (words_inc >= s.length) begin
						next_s.state = ST_WAIT;
						next_s.done_oe = 1'b0;
						next_s.ceo_n = 1'b0;
						next_s.link_run = 1'b0;
					end
				end
			end
		end
		ST_WAIT: begin
			if (s.dn2) begin
				next_s.state = ST_INIT;
				next_s.init_cnt = '0;
			end
		end
		ST_INIT: begin
			next_s.init_cnt = s.init_cnt + 4'h1;
			if (s.init_cnt == INIT_LAST) begin
				next_s.state = ST_USER;
				next_s.io_oe = 1'b1;
				next_s.user_mode = 1'b1;
			end
		end
		ST_USER: begin
			next_s.io_oe = 1'b1;
		end
		ST_ERROR: begin
			next_s.status_oe = 1'b1;
			next_s.link_run = 1'b0;
			if (!s.req2) begin
				next_s.state = ST_RESET;
			end
		end
		default: begin
			next_s.state = ST_POR;
		end
		endcase

		if (to_reset) begin
			next_s.state = ST_RESET;
			next_s.status_oe = !s.req2;
			next_s.link_run = 1'b0;
			next_s.words = '0;
			next_s.done_oe = 1'b1;
			next_s.ceo_n = 1'b1;
			next_s.io_oe = 1'b0;
			next_s.user_mode = 1'b0;
		end
		if (s.state == ST_RESET) begin
			next_s.words = '0;
			next_s.done_oe = 1'b1;
			next_s.ceo_n = 1'b1;
		end
		next_s.pullup_en = !s.pu2 && s.state != ST_POR
			&& s.state != ST_USER;

		// Bus slave: one wait state on every NONSEQ transfer
		if (s.bus_pend) begin
			next_s.bus_pend = 1'b0;
			next_s.hreadyout = 1'b1;
			if (s.bus_wr) begin
				if (s.bus_addr == LENGTH_OFS) begin
					next_s.length = ahb_i.hwdata[CNT_W-1:0];
				end
			end else begin
				next_s.hrdata = rd_word(s.bus_addr, s, mem_rdata);
			end
		end else if (ahb_i.hsel && ahb_i.htrans == HTRANS_NONSEQ
			&& ahb_i.hready) begin
			next_s.bus_pend = 1'b1;
			next_s.hreadyout = 1'b0;
			next_s.bus_wr = ahb_i.hwrite;
			next_s.bus_addr = ahb_i.haddr[ADDR_W-1:0];
		end
	end

	always_ff @(posedge ref_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			s <= SYS_RST;
		end else begin
			s <= next_s;
		end
	end

	// ****************************************************************
	// Outputs
	// ****************************************************************
	assign status_n_o           = 1'b0;
	assign status_n_oe_o        = s.status_oe;
	assign done_o               = 1'b0;
	assign done_oe_o            = s.done_oe;
	assign chain_enable_out_n_o = s.ceo_n;
	assign weak_pullup_en_o     = s.pullup_en;
	assign user_io_oe_o         = s.io_oe;
	assign user_mode_o          = s.user_mode;
	assign ahb_o.hreadyout      = s.hreadyout;
	assign ahb_o.hresp          = HRESP_OKAY;
	assign ahb_o.hrdata         = s.hrdata;

	// ****************************************************************
	// Assertions
	// ****************************************************************
	a_por_long_hold: assert property (@(posedge ref_clk_i)
		disable iff (!resetn_i)
		(s.state == ST_POR && !s.sel2 && !$changed(s.sel2)
			&& s.por_cnt < POR_CNT_W'(POR_LONG_CYC))
		|=> s.state == ST_POR)
		else $error("power-on reset left early");

	a_por_status_low: assert property (@(posedge ref_clk_i)
		disable iff (!resetn_i)
		s.state == ST_POR |-> status_n_oe_o && !user_io_oe_o)
		else $error("status not held low in power-on reset");

	a_pullup_follow: assert property (@(posedge ref_clk_i)
		disable iff (!resetn_i)
		(s.state == ST_CONFIG && $stable(s.pu2) && $stable(s.state))
		|=> weak_pullup_en_o == !$past(s.pu2))
		else $error("weak pull-up enable wrong");

	a_reset_on_low: assert property (@(posedge ref_clk_i)
		disable iff (!resetn_i)
		(s.state == ST_CONFIG && !s.req2) |=> s.state == ST_RESET)
		else $error("request low did not force reset");

	a_status_release: assert property (@(posedge ref_clk_i)
		disable iff (!resetn_i)
		(s.state == ST_RESET && s.req2) |=> !status_n_oe_o)
		else $error("status not released on request");

	a_done_held_low: assert property (@(posedge ref_clk_i)
		disable iff (!resetn_i)
		s.state == ST_CONFIG |-> done_oe_o && chain_enable_out_n_o)
		else $error("done released before last word");

	a_done_on_count: assert property (@(posedge ref_clk_i)
		disable iff (!resetn_i)
		(s.state == ST_CONFIG && word_ev && s.words != '0
			&& words_inc >= s.length && !to_reset)
		|=> !done_oe_o && s.state == ST_WAIT)
		else $error("done not released on full count");

	a_init_on_done: assert property (@(posedge ref_clk_i)
		disable iff (!resetn_i)
		(s.state == ST_WAIT && !s.dn2) |=> s.state != ST_INIT)
		else $error("initialization without shared done");

	a_user_no_clock: assert property (@(posedge ref_clk_i)
		disable iff (!resetn_i)
		(s.state == ST_INIT && s.init_cnt == '0 && s.req2 && s.st2)
		##1 (s.req2 && s.st2) [*8]
		|-> ##[0:1] user_mode_o)
		else $error("startup did not finish on its own");

	a_error_halts: assert property (@(posedge ref_clk_i)
		disable iff (!resetn_i)
		(s.state == ST_ERROR && s.req2) |=> status_n_oe_o && !s.link_run)
		else $error("error did not hold status low");

	a_link_gated: assert property (@(posedge config_clock_in_i)
		disable iff (!link_rst_n)
		chain_enable_in_n_i |=> $stable(l.bitcnt))
		else $error("bits taken while chain disabled");

endmodule : spcp_top

// >>> verilog/spcp_pkg.sv
// Constants and carrier types of the serial passive configuration port
package spcp_pkg;

	// ****************************************************************
	// Timing
	// ****************************************************************
	localparam int unsigned REF_CLK_HZ   = 10_000_000;
	localparam int unsigned POR_LONG_MS  = 100;
	localparam int unsigned POR_SHORT_MS = 12;
	localparam int unsigned CYC_PER_MS   = REF_CLK_HZ / 1000;
	localparam int          POR_CNT_W    = 20;
	localparam logic [3:0]  INIT_LAST    = 4'h7;

	// ****************************************************************
	// Data path
	// ****************************************************************
	localparam int          WORD_W   = 32;
	localparam logic [4:0]  BIT_LAST = 5'h1f;
	localparam int          MEM_AW   = 4;
	localparam int          CNT_W    = 16;
	localparam logic [31:0] PREAMBLE = 32'h5a5a_c3c3;

	// ****************************************************************
	// Register map
	// ****************************************************************
	localparam int          ADDR_W     = 8;
	localparam logic [7:0]  LENGTH_OFS = 8'h00;
	localparam logic [7:0]  STATUS_OFS = 8'h04;
	localparam logic [7:0]  COUNT_OFS  = 8'h08;
	localparam logic [1:0]  MEM_SEL    = 2'h1;
	localparam logic [15:0] LENGTH_RST = 16'h0010;
	localparam logic [1:0]  HTRANS_NONSEQ = 2'h2;
	localparam logic        HRESP_OKAY    = 1'b0;

	// ****************************************************************
	// Types
	// ****************************************************************
	typedef enum logic [2:0] {
		ST_POR    = 3'h0,
		ST_RESET  = 3'h1,
		ST_CONFIG = 3'h3,
		ST_WAIT   = 3'h2,
		ST_INIT   = 3'h6,
		ST_USER   = 3'h7,
		ST_ERROR  = 3'h5
	} spcp_state_t;

	typedef struct packed {
		logic        hsel;
		logic [31:0] haddr;
		logic [1:0]  htrans;
		logic        hwrite;
		logic [2:0]  hsize;
		logic [31:0] hwdata;
		logic        hready;
	} spcp_ahb_req_t;

	typedef struct packed {
		logic        hreadyout;
		logic        hresp;
		logic [31:0] hrdata;
	} spcp_ahb_rsp_t;

	typedef struct packed {
		logic [24:0] pad;
		logic        user_mode;
		logic        done_line;
		logic        done_released;
		logic        error;
		spcp_state_t state;
	} spcp_stat_t;

	typedef struct packed {
		spcp_state_t          state;
		logic [POR_CNT_W-1:0] por_cnt;
		logic [3:0]           init_cnt;
		logic                 req1, req2, st1, st2, dn1, dn2;
		logic                 sel1, sel2, pu1, pu2;
		logic                 tg1, tg2, tg3;
		logic                 link_run;
		logic [CNT_W-1:0]     length;
		logic [CNT_W-1:0]     words;
		logic                 error;
		logic                 status_oe;
		logic                 done_oe;
		logic                 ceo_n;
		logic                 pullup_en;
		logic                 io_oe;
		logic                 user_mode;
		logic                 bus_pend;
		logic                 bus_wr;
		logic [ADDR_W-1:0]    bus_addr;
		logic                 hreadyout;
		logic [WORD_W-1:0]    hrdata;
		logic                 mem_we;
		logic [MEM_AW-1:0]    mem_waddr;
		logic [WORD_W-1:0]    mem_wdata;
	} spcp_sys_t;

	typedef struct packed {
		logic [WORD_W-1:0] shift;
		logic [4:0]        bitcnt;
		logic [WORD_W-1:0] word;
		logic              tog;
	} spcp_link_t;

	localparam spcp_sys_t SYS_RST = '{
		state:     ST_POR,
		length:    LENGTH_RST,
		status_oe: 1'b1,
		done_oe:   1'b1,
		ceo_n:     1'b1,
		hreadyout: 1'b1,
		default:   '0
	};

endpackage : spcp_pkg

// >>> verilog/spcp_word_store.sv
// Small store of the first received configuration words
`timescale 1ns/100ps
module spcp_word_store (
	input  wire logic                       clk_i,
	input  wire logic                       resetn_i,
	input  wire logic                       we_i,
	input  wire logic [spcp_pkg::MEM_AW-1:0] waddr_i,
	input  wire logic [spcp_pkg::WORD_W-1:0] wdata_i,
	input  wire logic [spcp_pkg::MEM_AW-1:0] raddr_i,
	output logic      [spcp_pkg::WORD_W-1:0] rdata_o
);
	import spcp_pkg::*;

	logic [WORD_W-1:0] mem [2**MEM_AW];

	always_ff @(posedge clk_i) begin
		if (we_i) begin
			mem[waddr_i] <= wdata_i;
		end
	end

	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			rdata_o <= '0;
		end else begin
			rdata_o <= mem[raddr_i];
		end
	end

endmodule : spcp_word_store

// >>> testbench/spcp_host_model.sv
// Host end of the serial download cable
`timescale 1ns/100ps
module spcp_host_model (
	input  wire logic ref_clk_i,
	output logic      config_request_o,
	output logic      config_clock_o,
	output logic      serial_data_o
);
	// ****************************
	// Cable drive
	// ****************************
	// Clock and data idle high on their pull-ups
	initial begin
		config_request_o = 1'b0;
		config_clock_o   = 1'b1;
		serial_data_o    = 1'b1;
	end

	task automatic request(input logic v);
		@(posedge ref_clk_i);
		config_request_o <= v;
	endtask : request

	// One word MSB first; half sets the pace
	task automatic send_word(input logic [31:0] w, input int half);
		for (int i = 31; i >= 0; i--) begin
			config_clock_o = 1'b0;
			serial_data_o  = w[i];
			#(half) config_clock_o = 1'b1;
			#(half);
		end
		serial_data_o = 1'b1;
	endtask : send_word
endmodule : spcp_host_model

// >>> testbench/tb_spcp_top.sv
// Self-checking bench of the serial passive configuration port
`timescale 1ns/100ps
module tb_spcp_top;
	import spcp_pkg::*;
	localparam int unsigned LONG_CYC  = 200;
	localparam int unsigned SHORT_CYC = 50;
	logic          ref_clk_i, resetn_i, stat_pull, done_pull;
	logic          ce_in_n, por_sel, pullup_n, hsel, hwrite;
	logic [1:0]    htrans;
	logic [31:0]   haddr;
	logic [2:0]    hsize;
	logic [31:0]   hwdata, rd_s;
	logic          rdy_s, req, cclk, sdata;
	logic          stat_oe, done_oe, ceo_n, pu_en, io_oe, umode;
	logic          stat_d, done_d;
	logic [4:0]    watch;
	int            bad_count, samples_checked;
	spcp_ahb_req_t ahb_req;
	spcp_ahb_rsp_t ahb_rsp;

	// ****************************
	// Wiring
	// ****************************
	assign ahb_req = '{hsel: hsel, haddr: haddr, htrans: htrans,
		hwrite: hwrite, hsize: hsize, hwdata: hwdata,
		hready: ahb_rsp.hreadyout};
	assign watch = {io_oe, umode, ceo_n, done_oe, stat_oe};

	spcp_top #(.POR_LONG_CYC(LONG_CYC), .POR_SHORT_CYC(SHORT_CYC)) DUT (
		.ref_clk_i           (ref_clk_i),
		.resetn_i            (resetn_i),
		.config_clock_in_i   (cclk),
		.ahb_i               (ahb_req),
		.ahb_o               (ahb_rsp),
		.config_request_i    (req),
		.status_n_i          (~(stat_oe | stat_pull)),
		.status_n_o          (stat_d),
		.status_n_oe_o       (stat_oe),
		.done_i              (~(done_oe | done_pull)),
		.done_o              (done_d),
		.done_oe_o           (done_oe),
		.serial_data_in_i    (sdata),
		.chain_enable_in_n_i (ce_in_n),
		.chain_enable_out_n_o(ceo_n),
		.por_delay_select_i  (por_sel),
		.io_weak_pullup_n_i  (pullup_n),
		.weak_pullup_en_o    (pu_en),
		.user_io_oe_o        (io_oe),
		.user_mode_o         (umode)
	);

	spcp_host_model host (
		.ref_clk_i       (ref_clk_i),
		.config_request_o(req),
		.config_clock_o  (cclk),
		.serial_data_o   (sdata)
	);

	always #50 ref_clk_i = ~ref_clk_i;

	always @(posedge ref_clk_i) begin
		rdy_s <= ahb_rsp.hreadyout;
		rd_s  <= ahb_rsp.hrdata;
	end

	// ****************************
	// Helpers
	// ****************************
	task automatic tick();
		@(posedge ref_clk_i);
		#1;
	endtask : tick

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			bad_count++;
			$display("CHECK FAILED at %0t: seen %h expected %h",
				$time, seen, exp);
		end
	endtask : check

	task automatic give_verdict();
		$display("checks %0d mismatches %0d", samples_checked, bad_count);
		if (bad_count == 0 && samples_checked > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : give_verdict

	task automatic wait_val(input int i, input logic v, input int lim);
		int n;
		n = 0;
		while (watch[i] !== v && n < lim) begin
			tick();
			n++;
		end
		if (watch[i] !== v) begin
			check(32'(watch[i]), 32'(v));
			give_verdict();
		end
	endtask : wait_val

	// Single AHB word transfer, one slave
	task automatic bus(input logic wr, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] r);
		int n;
		n = 0;
		tick();
		hsel   <= 1'b1;
		hwrite <= wr;
		haddr  <= {24'h0, a};
		hsize  <= 3'h2;
		htrans <= HTRANS_NONSEQ;
		do begin
			tick();
			n++;
		end while (rdy_s !== 1'b1 && n < 40);
		hsel   <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		do begin
			tick();
			n++;
		end while (rdy_s !== 1'b1 && n < 40);
		r = rd_s;
		if (n >= 40) begin
			check(32'h0, 32'h1);
			give_verdict();
		end
	endtask : bus

	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] r;
		bus(1'b0, a, 32'h0, r);
		check(r, exp);
	endtask : rd

	task automatic do_reset(input logic sel);
		host.request(1'b0);
		tick();
		resetn_i <= 1'b0;
		por_sel  <= sel;
		repeat (16) tick();
		resetn_i <= 1'b1;
	endtask : do_reset

	// ****************************
	// Scenarios
	// ****************************
	task automatic t_por(input logic sel, input int unsigned cyc);
		do_reset(sel);
		repeat (4) tick();
		host.request(1'b1);
		repeat (cyc - 12) tick();
		check(32'(stat_oe), 32'h1);
		check(32'(io_oe), 32'h0);
		check(32'(stat_d), 32'h0);
		wait_val(0, 1'b0, 24);
		check(32'(pu_en), 32'h1);
		$display("test por end");
	endtask : t_por

	task automatic t_load();
		logic [31:0] r;
		rd(LENGTH_OFS, {16'h0, LENGTH_RST});
		bus(1'b1, LENGTH_OFS, 32'h3, r);
		rd(LENGTH_OFS, 32'h3);
		rd(8'h0c, 32'h0);
		repeat (8) tick();
		rd(STATUS_OFS, 32'h3);
		pullup_n <= 1'b1;
		repeat (4) tick();
		check(32'(pu_en), 32'h0);
		pullup_n <= 1'b0;
		repeat (4) tick();
		check(32'(pu_en), 32'h1);
		done_pull <= 1'b1;
		host.send_word(PREAMBLE, 15);
		host.send_word(32'h1234_abcd, 15);
		repeat (10) tick();
		check(32'(done_oe), 32'h1);
		host.send_word(32'h0f0f_5555, 15);
		wait_val(1, 1'b0, 12);
		check(32'(done_d), 32'h0);
		wait_val(2, 1'b0, 4);
		repeat (30) tick();
		check(32'(umode), 32'h0);
		rd(STATUS_OFS, 32'h12);
		done_pull <= 1'b0;
		wait_val(3, 1'b1, 20);
		check(32'(io_oe), 32'h1);
		rd(COUNT_OFS, 32'h3);
		rd(8'h44, 32'h1234_abcd);
		$display("test load end");
	endtask : t_load

	task automatic t_error();
		host.request(1'b0);
		wait_val(3, 1'b0, 8);
		pullup_n <= 1'b1;
		repeat (6) tick();
		check(32'(pu_en), 32'h0);
		pullup_n <= 1'b0;
		host.request(1'b1);
		wait_val(0, 1'b0, 12);
		repeat (8) tick();
		host.send_word(32'hdead_0001, 15);
		wait_val(0, 1'b1, 12);
		rd(STATUS_OFS, 32'h0d);
		repeat (40) tick();
		check(32'(stat_oe), 32'h1);
		host.request(1'b0);
		repeat (6) tick();
		host.request(1'b1);
		wait_val(0, 1'b0, 12);
		$display("test error end");
	endtask : t_error

	task automatic t_chain();
		repeat (8) tick();
		ce_in_n <= 1'b1;
		host.send_word(PREAMBLE, 15);
		tick();
		ce_in_n <= 1'b0;
		host.send_word(PREAMBLE, 15);
		host.send_word(32'h0000_0001, 15);
		repeat (10) tick();
		check(32'(done_oe), 32'h1);
		host.send_word(32'h8000_0000, 15);
		wait_val(1, 1'b0, 12);
		rd(8'h48, 32'h8000_0000);
		wait_val(3, 1'b1, 20);
		stat_pull <= 1'b1;
		wait_val(3, 1'b0, 8);
		stat_pull <= 1'b0;
		$display("test chain end");
	endtask : t_chain

	initial begin
		ref_clk_i       = 1'b0;
		resetn_i        = 1'b0;
		stat_pull       = 1'b0;
		done_pull       = 1'b0;
		ce_in_n         = 1'b0;
		por_sel         = 1'b0;
		pullup_n        = 1'b0;
		hsel            = 1'b0;
		hwrite          = 1'b0;
		htrans          = 2'h0;
		haddr           = 32'h0;
		hsize           = 3'h0;
		hwdata          = 32'h0;
		bad_count       = 0;
		samples_checked = 0;
		t_por(1'b0, LONG_CYC);
		t_por(1'b1, SHORT_CYC);
		t_load();
		t_error();
		t_chain();
		give_verdict();
	end
endmodule : tb_spcp_top
